/* nph_pkg.sv */
package nph_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_FEAT = 8'h04;
  localparam logic [7:0] ADR_BUFLEN = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0C;
  localparam logic [7:0] ADR_RXCNT = 8'h10;
  localparam logic [7:0] ADR_DROPCNT = 8'h14;
  localparam logic [7:0] ADR_TXCNT = 8'h18;

  localparam logic CTRL_EN_RST = 1'h0;
  localparam logic [11:0] FEAT_RST = 12'h000;
  localparam logic [16:0] BUFLEN_RST = 17'h005F6;

  // ----------------------------------------
  // Feature bit positions in the feature register
  // ----------------------------------------
  localparam int F_HCSUM = 0;
  localparam int F_GCSUM = 1;
  localparam int F_HTSO4 = 2;
  localparam int F_HTSO6 = 3;
  localparam int F_HUFO = 4;
  localparam int F_HECN = 5;
  localparam int F_GTSO4 = 6;
  localparam int F_GTSO6 = 7;
  localparam int F_GUFO = 8;
  localparam int F_GECN = 9;
  localparam int F_MRG = 10;
  localparam int F_RSC = 11;

  // ----------------------------------------
  // Header encodings and sizes
  // ----------------------------------------
  localparam int FLG_NEEDS_CSUM = 0;
  localparam int FLG_DATA_VALID = 1;
  localparam int FLG_RSC_INFO = 2;
  localparam int GSO_ECN_BIT = 7;
  localparam logic [6:0] GSO_NONE = 7'h00;
  localparam logic [6:0] GSO_TCPV4 = 7'h01;
  localparam logic [6:0] GSO_UDP = 7'h03;
  localparam logic [6:0] GSO_TCPV6 = 7'h04;
  localparam logic [16:0] HDR_BYTES = 17'h0000C;
  localparam logic [16:0] MAX_PKT_SEG = 17'h1000E;
  localparam logic [16:0] MAX_PKT_STD = 17'h005EA;

  typedef enum logic [1:0] {RX_IDLE, RX_SPLIT} nph_rx_e;
  typedef enum logic [1:0] {SP_IDLE, SP_COUNT, SP_EMIT} nph_split_e;

  // Segmentation type is legal only with its matching feature
  function automatic logic gso_allowed(input logic [6:0] t, input logic tso4,
                                       input logic tso6, input logic ufo);
    gso_allowed = (t == GSO_NONE) | ((t == GSO_TCPV4) & tso4) |
                  ((t == GSO_TCPV6) & tso6) | ((t == GSO_UDP) & ufo);
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      wb_merge[8*i +: 8] = sel[i] ? dat[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

endpackage

/* nph_tx_decode.sv */
`timescale 1ns/100ps
module nph_tx_decode (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Latched features
  input wire logic [11:0] feat_i,
  // Transmit header in
  input wire logic valid_i,
  input wire logic [7:0] flags_i,
  input wire logic [7:0] gso_i,
  input wire logic [15:0] hdr_len_i,
  input wire logic [15:0] gso_size_i,
  input wire logic [15:0] csum_start_i,
  input wire logic [15:0] csum_off_i,
  // Decoded header out
  output logic valid_o,
  output logic csum_ins_o,
  output logic [15:0] csum_start_o,
  output logic [15:0] csum_off_o,
  output logic csum_check_o,
  output logic [7:0] seg_type_o,
  output logic [15:0] seg_size_o,
  output logic [15:0] hdr_hint_o,
  output logic bad_o
);
  import nph_pkg::*;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire need = flags_i[FLG_NEEDS_CSUM] & feat_i[F_HCSUM];
  wire host_seg = feat_i[F_HTSO4] | feat_i[F_HTSO6] | feat_i[F_HUFO];
  wire seg_ok = gso_allowed(gso_i[6:0], feat_i[F_HTSO4], feat_i[F_HTSO6],
                            feat_i[F_HUFO]);
  wire seg = (gso_i[6:0] != GSO_NONE) & seg_ok;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      csum_ins_o <= 1'b0;
      csum_start_o <= 16'h0000;
      csum_off_o <= 16'h0000;
      csum_check_o <= 1'b0;
      seg_type_o <= 8'h00;
      seg_size_o <= 16'h0000;
      hdr_hint_o <= 16'h0000;
      bad_o <= 1'b0;
    end else begin
      valid_o <= valid_i;
      if (valid_i) begin
        csum_ins_o <= need;
        csum_start_o <= need ? csum_start_i : 16'h0000;
        csum_off_o <= need ? csum_off_i : 16'h0000;
        csum_check_o <= ~need;
        seg_type_o <= seg ? {gso_i[7] & feat_i[F_HECN], gso_i[6:0]} : 8'h00;
        seg_size_o <= seg ? gso_size_i : 16'h0000;
        hdr_hint_o <= host_seg ? hdr_len_i : 16'h0000;
        bad_o <= ~seg_ok;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_tx_csum_gate: assert property (valid_i && !need |=> valid_o && csum_check_o && csum_start_o == 16'h0000 && csum_off_o == 16'h0000) else $error("unflagged checksum fields used");
  a_tx_hint_only: assert property (valid_i && !host_seg |=> hdr_hint_o == 16'h0000) else $error("header length passed without segmentation");

endmodule

/* nph_rx_split.sv */
`timescale 1ns/100ps
module nph_rx_split #(
  parameter int LW = 17
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Job
  input wire logic start_i,
  input wire logic merge_i,
  input wire logic [LW-1:0] total_i,
  input wire logic [LW-1:0] buf_len_i,
  // Per-buffer output
  output logic busy_o,
  output logic buf_valid_o,
  output logic [LW-1:0] buf_len_o,
  output logic buf_first_o,
  output logic buf_last_o,
  output logic [15:0] count_o,
  output logic done_o
);
  import nph_pkg::*;

  nph_split_e st_q;
  logic [LW-1:0] rem_q;
  logic [LW-1:0] tot_q;
  logic [LW-1:0] blen_q;
  logic [15:0] idx_q;

  // ----------------------------------------
  // Count buffers first so the header carries the count, then emit
  // ----------------------------------------
  wire fits = rem_q <= blen_q;
  wire [LW-1:0] take = fits ? rem_q : blen_q;

  assign busy_o = st_q != SP_IDLE;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= SP_IDLE;
      rem_q <= '0;
      tot_q <= '0;
      blen_q <= '0;
      idx_q <= 16'h0000;
      count_o <= 16'h0000;
      buf_valid_o <= 1'b0;
      buf_len_o <= '0;
      buf_first_o <= 1'b0;
      buf_last_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      buf_valid_o <= 1'b0;
      done_o <= 1'b0;
      case (st_q)
        SP_IDLE: if (start_i) begin
          tot_q <= total_i;
          rem_q <= total_i;
          blen_q <= merge_i ? buf_len_i : total_i;
          count_o <= 16'h0000;
          st_q <= SP_COUNT;
        end
        SP_COUNT: begin
          count_o <= count_o + 16'h0001;
          rem_q <= fits ? tot_q : rem_q - blen_q;
          idx_q <= 16'h0000;
          if (fits) st_q <= SP_EMIT;
        end
        SP_EMIT: begin
          buf_valid_o <= 1'b1;
          buf_len_o <= take;
          buf_first_o <= idx_q == 16'h0000;
          buf_last_o <= fits;
          idx_q <= idx_q + 16'h0001;
          rem_q <= rem_q - take;
          if (fits) begin
            done_o <= 1'b1;
            st_q <= SP_IDLE;
          end
        end
        default: st_q <= SP_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_nonlast_full: assert property (buf_valid_o && !buf_last_o |-> buf_len_o == blen_q) else $error("non-final buffer not filled");
  a_done_last: assert property (done_o |-> buf_valid_o && buf_last_o && idx_q == count_o) else $error("commit count mismatch");

endmodule

/* nph_offload.sv */
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module nph_offload #(
  parameter int LW = 17
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Transmit header in
  input wire logic tx_hdr_valid_i,
  input wire logic [7:0] tx_flags_i,
  input wire logic [7:0] tx_gso_type_i,
  input wire logic [15:0] tx_hdr_len_i,
  input wire logic [15:0] tx_gso_size_i,
  input wire logic [15:0] tx_csum_start_i,
  input wire logic [15:0] tx_csum_off_i,
  output logic tx_hdr_ready_o,
  // Transmit decode out
  output logic tx_valid_o,
  output logic tx_csum_ins_o,
  output logic [15:0] tx_csum_start_o,
  output logic [15:0] tx_csum_off_o,
  output logic tx_csum_check_o,
  output logic [7:0] tx_seg_type_o,
  output logic [15:0] tx_seg_size_o,
  output logic [15:0] tx_hdr_hint_o,
  output logic tx_bad_o,
  // Receive packet in
  input wire logic rx_pkt_valid_i,
  input wire logic [LW-1:0] rx_len_i,
  input wire logic [6:0] rx_gso_i,
  input wire logic [15:0] rx_mss_i,
  input wire logic [15:0] rx_hdr_len_i,
  input wire logic rx_ecn_ce_i,
  input wire logic rx_csum_ok_i,
  input wire logic [15:0] rx_csum_start_i,
  input wire logic [15:0] rx_csum_off_i,
  input wire logic [15:0] rx_coal_cnt_i,
  input wire logic [15:0] rx_dupack_i,
  output logic rx_pkt_ready_o,
  // Receive header out
  output logic [7:0] rx_hdr_flags_o,
  output logic [7:0] rx_hdr_gso_type_o,
  output logic [15:0] rx_hdr_len_o,
  output logic [15:0] rx_hdr_gso_size_o,
  output logic [15:0] rx_hdr_csum_start_o,
  output logic [15:0] rx_hdr_csum_off_o,
  output logic [15:0] rx_hdr_num_bufs_o,
  output logic rx_pseudo_o,
  output logic rx_fill_csum_o,
  // Receive buffers out
  output logic rx_buf_valid_o,
  output logic [LW-1:0] rx_buf_len_o,
  output logic rx_buf_first_o,
  output logic rx_buf_last_o,
  output logic rx_commit_o,
  output logic rx_drop_o
);
  import nph_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic en_q;
  logic [11:0] feat_q;
  logic [16:0] buflen_q;
  logic [15:0] rxcnt_q;
  logic [15:0] dropcnt_q;
  logic [15:0] txcnt_q;
  nph_rx_e st_q;

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;
  wire wr_ctrl = wb_wr & (wb_adr_i == ADR_CTRL);
  wire wr_feat = wb_wr & (wb_adr_i == ADR_FEAT) & ~en_q;
  wire wr_buflen = wb_wr & (wb_adr_i == ADR_BUFLEN) & ~en_q;
  wire [31:0] ctrl_m = wb_merge({31'h00000000, en_q}, wb_dat_i, wb_sel_i);
  wire [31:0] feat_m = wb_merge({20'h00000, feat_q}, wb_dat_i, wb_sel_i);
  wire [31:0] blen_m = wb_merge({15'h0000, buflen_q}, wb_dat_i, wb_sel_i);

  wire [31:0] rd_data =
    (wb_adr_i == ADR_CTRL) ? {31'h00000000, en_q} :
    (wb_adr_i == ADR_FEAT) ? {20'h00000, feat_q} :
    (wb_adr_i == ADR_BUFLEN) ? {15'h0000, buflen_q} :
    (wb_adr_i == ADR_STAT) ? {30'h00000000, st_q != RX_IDLE, en_q} :
    (wb_adr_i == ADR_RXCNT) ? {16'h0000, rxcnt_q} :
    (wb_adr_i == ADR_DROPCNT) ? {16'h0000, dropcnt_q} :
    (wb_adr_i == ADR_TXCNT) ? {16'h0000, txcnt_q} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      en_q <= CTRL_EN_RST;
      feat_q <= FEAT_RST;
      buflen_q <= BUFLEN_RST;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req & ~wb_we_i ? rd_data : 32'h00000000;
      if (wr_ctrl) en_q <= ctrl_m[0];
      if (wr_feat) feat_q <= feat_m[11:0];
      if (wr_buflen) buflen_q <= blen_m[16:0];
    end
  end

  // ----------------------------------------
  // Transmit header decode
  // ----------------------------------------
  assign tx_hdr_ready_o = en_q;

  nph_tx_decode u_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .feat_i(feat_q),
    .valid_i(tx_hdr_valid_i & en_q),
    .flags_i(tx_flags_i),
    .gso_i(tx_gso_type_i),
    .hdr_len_i(tx_hdr_len_i),
    .gso_size_i(tx_gso_size_i),
    .csum_start_i(tx_csum_start_i),
    .csum_off_i(tx_csum_off_i),
    .valid_o(tx_valid_o),
    .csum_ins_o(tx_csum_ins_o),
    .csum_start_o(tx_csum_start_o),
    .csum_off_o(tx_csum_off_o),
    .csum_check_o(tx_csum_check_o),
    .seg_type_o(tx_seg_type_o),
    .seg_size_o(tx_seg_size_o),
    .hdr_hint_o(tx_hdr_hint_o),
    .bad_o(tx_bad_o)
  );

  // ----------------------------------------
  // Receive header composition
  // ----------------------------------------
  wire f_gcsum = feat_q[F_GCSUM];
  wire f_mrg = feat_q[F_MRG];
  wire f_rsc = feat_q[F_RSC];
  wire g_seg = feat_q[F_GTSO4] | feat_q[F_GTSO6] | feat_q[F_GUFO];
  wire seg_req = rx_gso_i != GSO_NONE;
  wire seg_ok = gso_allowed(rx_gso_i, feat_q[F_GTSO4], feat_q[F_GTSO6],
                            feat_q[F_GUFO]) & f_gcsum & rx_csum_ok_i;
  wire ecn_blk = seg_req & rx_ecn_ce_i & ~feat_q[F_GECN];
  wire [LW-1:0] max_len = g_seg ? LW'(MAX_PKT_SEG) : LW'(MAX_PKT_STD);
  wire [LW-1:0] total = rx_len_i + LW'(HDR_BYTES);
  wire no_fit = f_mrg ? (buflen_q < HDR_BYTES) : (total > buflen_q);
  wire drop = (rx_len_i > max_len) | (seg_req & ~seg_ok) | ecn_blk | no_fit;
  wire need = seg_req & seg_ok;
  wire rsc = need & f_rsc;
  wire dvalid = f_gcsum & rx_csum_ok_i & ~need;
  wire [7:0] flags = {5'h00, rsc, dvalid, need};
  wire [7:0] gso = need ? {rx_ecn_ce_i, rx_gso_i} : {1'h0, GSO_NONE};
  wire accept = rx_pkt_valid_i & rx_pkt_ready_o;
  wire sp_done;
  wire [15:0] sp_count;

  assign rx_pkt_ready_o = en_q & (st_q == RX_IDLE);
  assign rx_commit_o = sp_done;
  assign rx_hdr_num_bufs_o = sp_count;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= RX_IDLE;
      rx_hdr_flags_o <= 8'h00;
      rx_hdr_gso_type_o <= 8'h00;
      rx_hdr_len_o <= 16'h0000;
      rx_hdr_gso_size_o <= 16'h0000;
      rx_hdr_csum_start_o <= 16'h0000;
      rx_hdr_csum_off_o <= 16'h0000;
      rx_pseudo_o <= 1'b0;
      rx_fill_csum_o <= 1'b0;
      rx_drop_o <= 1'b0;
    end else begin
      rx_drop_o <= accept & drop;
      case (st_q)
        RX_IDLE: if (accept & ~drop) begin
          st_q <= RX_SPLIT;
          rx_hdr_flags_o <= flags;
          rx_hdr_gso_type_o <= gso;
          rx_hdr_gso_size_o <= need ? rx_mss_i : 16'h0000;
          rx_hdr_len_o <= g_seg ? rx_hdr_len_i : 16'h0000;
          rx_hdr_csum_start_o <= rsc ? rx_coal_cnt_i :
                                 need ? rx_csum_start_i : 16'h0000;
          rx_hdr_csum_off_o <= rsc ? rx_dupack_i :
                               need ? rx_csum_off_i : 16'h0000;
          rx_pseudo_o <= need & ~rsc;
          rx_fill_csum_o <= ~need;
        end
        RX_SPLIT: if (sp_done) st_q <= RX_IDLE;
        default: st_q <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Buffer split and merge count
  // ----------------------------------------
  nph_rx_split #(.LW(LW)) u_split (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(accept & ~drop),
    .merge_i(f_mrg),
    .total_i(total),
    .buf_len_i(buflen_q),
    .busy_o(),
    .buf_valid_o(rx_buf_valid_o),
    .buf_len_o(rx_buf_len_o),
    .buf_first_o(rx_buf_first_o),
    .buf_last_o(rx_buf_last_o),
    .count_o(sp_count),
    .done_o(sp_done)
  );

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxcnt_q <= 16'h0000;
      dropcnt_q <= 16'h0000;
      txcnt_q <= 16'h0000;
    end else begin
      if (sp_done) rxcnt_q <= rxcnt_q + 16'h0001;
      if (rx_drop_o) dropcnt_q <= dropcnt_q + 16'h0001;
      if (tx_valid_o) txcnt_q <= txcnt_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_flags_zero_nocsum: assert property (rx_commit_o && !f_gcsum |-> rx_hdr_flags_o == 8'h00) else $error("flags set without guest checksum");
  a_rsc_info_gate: assert property (rx_commit_o && !f_rsc |-> !rx_hdr_flags_o[FLG_RSC_INFO]) else $error("RSC_INFO without extension");
  a_seg_sets_csum: assert property (accept && !drop && seg_req |=> rx_hdr_flags_o[FLG_NEEDS_CSUM] && rx_hdr_gso_size_o == $past(rx_mss_i)) else $error("segment lacks checksum or size");
  a_single_buffer: assert property (rx_commit_o && !f_mrg |-> rx_hdr_num_bufs_o == 16'h0001) else $error("count not one without merging");
  a_gso_feature: assert property (rx_commit_o && rx_hdr_gso_type_o[6:0] == GSO_TCPV4 |-> feat_q[F_GTSO4]) else $error("TCPv4 type without feature");
  a_ecn_gate: assert property (accept && seg_req && rx_ecn_ce_i && !feat_q[F_GECN] |=> rx_drop_o && st_q == RX_IDLE) else $error("congestion-marked packet delivered");
  a_feat_frozen: assert property (en_q && $past(en_q) |-> $stable(feat_q)) else $error("features changed while enabled");
  a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");

endmodule

/* nph_drv_model.sv */
`timescale 1ns/100ps
module nph_drv_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Buffers handed back by the device
  input wire logic buf_valid_i,
  input wire logic [16:0] buf_len_i,
  input wire logic buf_first_i,
  input wire logic buf_last_i,
  input wire logic commit_i,
  input wire logic [16:0] slot_len_i,
  input wire logic [7:0] flags_i,
  // Driver accounting
  output logic [15:0] nbufs_o,
  output logic [16:0] total_o,
  output logic csum_use_o,
  output logic [7:0] errs_o
);
  logic in_pkt_q;

  // ----------------------------------------
  // Checksum fields trusted only when meaningful
  // ----------------------------------------
  assign csum_use_o = flags_i[0] & ~flags_i[2];

  // ----------------------------------------
  // Receive buffer accounting
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nbufs_o <= 16'h0000;
      total_o <= 17'h00000;
      in_pkt_q <= 1'b0;
      errs_o <= 8'h00;
    end else if (buf_valid_i) begin
      nbufs_o <= buf_first_i ? 16'h0001 : nbufs_o + 16'h0001;
      total_o <= buf_first_i ? buf_len_i : total_o + buf_len_i;
      in_pkt_q <= ~buf_last_i;
      if (buf_first_i == in_pkt_q) begin
        errs_o <= errs_o + 8'h01;
      end else if (!buf_last_i && buf_len_i != slot_len_i) begin
        errs_o <= errs_o + 8'h01;
      end else if (commit_i != buf_last_i) begin
        errs_o <= errs_o + 8'h01;
      end
    end
  end
endmodule

/* net_packet_header_offload_tb_top.sv */
`timescale 1ns/100ps
module net_packet_header_offload_tb_top;
  import nph_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic txv = 1'b0, rxv = 1'b0, ce = 1'b0, cok = 1'b1;
  logic [7:0] adr = 8'h00, txf = 8'h00, txg = 8'h00;
  logic [31:0] wdat = 32'h0, rd;
  logic [16:0] rlen = 17'h0, slot = 17'h005F6;
  logic [6:0] rg = 7'h00;
  logic [15:0] f1 = 16'h05B4, f2 = 16'h0036, f3 = 16'h0022, f4 = 16'h0010;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, tx_valid_o, tx_csum_ins_o, tx_csum_check_o, tx_bad_o, rx_pkt_ready_o;
  logic [15:0] tx_csum_start_o, tx_hdr_hint_o, gsz, cst, cof, nbh, nbm;
  logic [7:0] flg, gty, errs;
  logic bv, bf, bl, cm, dr, cu, trdy, ps, fc;
  logic [15:0] tco, tss, rhl;
  logic [7:0] tst;
  logic [16:0] bln, tot;
  int fails = 0, num_checks = 0;

  always #12.5 clk_i = ~clk_i;

  nph_offload #(.LW(17)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tx_hdr_valid_i(txv), .tx_flags_i(txf), .tx_gso_type_i(txg),
    .tx_hdr_len_i(f2), .tx_gso_size_i(f1), .tx_csum_start_i(f3), .tx_csum_off_i(f4),
    .tx_hdr_ready_o(trdy), .tx_valid_o(tx_valid_o), .tx_csum_ins_o(tx_csum_ins_o),
    .tx_csum_start_o(tx_csum_start_o), .tx_csum_off_o(tco), .tx_csum_check_o(tx_csum_check_o),
    .tx_seg_type_o(tst), .tx_seg_size_o(tss), .tx_hdr_hint_o(tx_hdr_hint_o), .tx_bad_o(tx_bad_o),
    .rx_pkt_valid_i(rxv), .rx_len_i(rlen), .rx_gso_i(rg), .rx_mss_i(f1), .rx_hdr_len_i(f2),
    .rx_ecn_ce_i(ce), .rx_csum_ok_i(cok), .rx_csum_start_i(f3), .rx_csum_off_i(f4),
    .rx_coal_cnt_i(f3 ^ 16'h0005), .rx_dupack_i(f4 ^ 16'h0003), .rx_pkt_ready_o(rx_pkt_ready_o),
    .rx_hdr_flags_o(flg), .rx_hdr_gso_type_o(gty), .rx_hdr_len_o(rhl), .rx_hdr_gso_size_o(gsz),
    .rx_hdr_csum_start_o(cst), .rx_hdr_csum_off_o(cof), .rx_hdr_num_bufs_o(nbh),
    .rx_pseudo_o(ps), .rx_fill_csum_o(fc), .rx_buf_valid_o(bv), .rx_buf_len_o(bln),
    .rx_buf_first_o(bf), .rx_buf_last_o(bl), .rx_commit_o(cm), .rx_drop_o(dr));

  nph_drv_model drv (.clk_i(clk_i), .rst_i(rst_i), .buf_valid_i(bv), .buf_len_i(bln),
    .buf_first_i(bf), .buf_last_i(bl), .commit_i(cm), .slot_len_i(slot), .flags_i(flg),
    .nbufs_o(nbm), .total_o(tot), .csum_use_o(cu), .errs_o(errs));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic cfg(input logic [31:0] ft, input logic [16:0] bl_v);
    wb(1'b1, ADR_CTRL, 32'h0);
    wb(1'b1, ADR_FEAT, ft);
    wb(1'b1, ADR_BUFLEN, 32'(bl_v));
    wb(1'b1, ADR_CTRL, 32'h1);
    slot = bl_v;
  endtask

  task automatic tx(input logic [7:0] f, input logic [7:0] g);
    @(posedge clk_i);
    txv <= 1'b1;
    txf <= f;
    txg <= g;
    @(posedge clk_i);
    txv <= 1'b0;
    @(negedge clk_i);
    chk("tx_valid", 32'h1, 32'(tx_valid_o));
  endtask

  task automatic rx(input logic [16:0] l, input logic [6:0] g, input logic c, input logic d);
    int n;
    n = 0;
    @(posedge clk_i);
    rxv <= 1'b1;
    rlen <= l;
    rg <= g;
    ce <= c;
    do @(posedge clk_i); while (rx_pkt_ready_o !== 1'b1);
    rxv <= 1'b0;
    rlen <= ~l;
    do begin
      @(negedge clk_i);
      n++;
    end while (cm !== 1'b1 && dr !== 1'b1 && n < 400);
    chk("rx_end", 32'h1, 32'(cm | dr));
    chk("rx_drop", 32'(d), 32'(dr));
    // Let the driver model register the final buffer
    @(negedge clk_i);
  endtask

  task automatic hdr(input logic [15:0] nb, input logic [7:0] f, input logic [7:0] g);
    chk("num_bufs", 32'(nb), 32'(nbh));
    chk("model_bufs", 32'(nb), 32'(nbm));
    chk("flags", 32'(f), 32'(flg));
    chk("gso_type", 32'(g), 32'(gty));
    chk("model_errs", 32'h0, 32'(errs));
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADR_FEAT, 32'h0);
    chk("feat_rst", 32'(FEAT_RST), rd);
    wb(1'b0, ADR_BUFLEN, 32'h0);
    chk("buflen_rst", 32'(BUFLEN_RST), rd);
    chk("tx_ready_rst", 32'h0, 32'(trdy));
    wb(1'b1, 8'h1C, 32'hFFFFFFFF);
    wb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h0, rd);
    cfg(32'h0, BUFLEN_RST);
    wb(1'b1, ADR_FEAT, 32'h00000FFF);
    wb(1'b0, ADR_FEAT, 32'h0);
    chk("feat_locked", 32'h0, rd);
    $display("test registers done");
    tx(8'hFE, 8'h01);
    chk("tx_csum_ins", 32'h0, 32'(tx_csum_ins_o));
    chk("tx_csum_start", 32'h0, 32'(tx_csum_start_o));
    chk("tx_csum_check", 32'h1, 32'(tx_csum_check_o));
    chk("tx_hint", 32'h0, 32'(tx_hdr_hint_o));
    chk("tx_bad", 32'h1, 32'(tx_bad_o));
    chk("tx_ready", 32'h1, 32'(trdy));
    chk("tx_csum_off", 32'h0, 32'(tco));
    chk("tx_seg_type", 32'h0, 32'(tst));
    chk("tx_seg_size", 32'h0, 32'(tss));
    cfg(32'(1 << F_HCSUM), BUFLEN_RST);
    tx(8'h01, 8'h00);
    chk("tx_csum_ins", 32'h1, 32'(tx_csum_ins_o));
    chk("tx_csum_start", 32'(f3), 32'(tx_csum_start_o));
    chk("tx_csum_off", 32'(f4), 32'(tco));
    cfg(32'((1 << F_HCSUM) | (1 << F_HTSO4) | (1 << F_HECN)), BUFLEN_RST);
    tx(8'h01, 8'h81);
    chk("tx_seg_type", 32'h81, 32'(tst));
    chk("tx_seg_size", 32'(f1), 32'(tss));
    chk("tx_hint", 32'(f2), 32'(tx_hdr_hint_o));
    chk("tx_bad", 32'h0, 32'(tx_bad_o));
    $display("test transmit done");
    cfg(32'h0, BUFLEN_RST);
    rx(17'd1514, GSO_NONE, 1'b0, 1'b0);
    hdr(16'h1, 8'h00, 8'h00);
    chk("model_total", 32'd1526, 32'(tot));
    chk("rx_hdr_len", 32'h0, 32'(rhl));
    chk("fill_csum", 32'h1, 32'(fc));
    chk("pseudo", 32'h0, 32'(ps));
    rx(17'd1515, GSO_NONE, 1'b0, 1'b1);
    rx(17'd100, GSO_TCPV4, 1'b0, 1'b1);
    $display("test plain receive done");
    cfg(32'((1 << F_GCSUM) | (1 << F_GTSO4) | (1 << F_MRG)), 17'd100);
    rx(17'd138, GSO_TCPV4, 1'b0, 1'b0);
    hdr(16'h2, 8'h01, 8'h01);
    chk("gso_size", 32'(f1), 32'(gsz));
    chk("model_total", 32'd150, 32'(tot));
    chk("csum_use", 32'h1, 32'(cu));
    chk("rx_hdr_len", 32'(f2), 32'(rhl));
    chk("pseudo", 32'h1, 32'(ps));
    chk("fill_csum", 32'h0, 32'(fc));
    rx(17'd88, GSO_NONE, 1'b0, 1'b0);
    hdr(16'h1, 8'h02, 8'h00);
    rx(17'd138, GSO_TCPV6, 1'b0, 1'b1);
    rx(17'd138, GSO_TCPV4, 1'b1, 1'b1);
    @(posedge clk_i);
    cok <= 1'b0;
    rx(17'd138, GSO_TCPV4, 1'b0, 1'b1);
    @(posedge clk_i);
    cok <= 1'b1;
    $display("test merged receive done");
    cfg(32'((1 << F_GCSUM) | (1 << F_GTSO4) | (1 << F_GECN) | (1 << F_MRG) | (1 << F_RSC)),
        17'd100);
    rx(17'd300, GSO_TCPV4, 1'b1, 1'b0);
    hdr(16'h4, 8'h05, 8'h81);
    chk("coal_cnt", 32'(f3 ^ 16'h0005), 32'(cst));
    chk("dup_acks", 32'(f4 ^ 16'h0003), 32'(cof));
    chk("csum_use", 32'h0, 32'(cu));
    chk("pseudo", 32'h0, 32'(ps));
    $display("test coalesced receive done");
    stop_test();
  end
endmodule
